/* File: hdl/dacc_unit.sv */
// d-unit accumulator datapath with width, saturation and extension modes
// assumes an apb master on pclk; operations are issued by writing the command word
//
// Overview of operation
// - narrow mode: sign, carry, overflow at bit 31
// - wide mode: sign, carry, overflow at bit 39
// - narrow mode: zero test and shifts use 32 bits
// - wide mode: zero test and shifts use 40 bits
// - shift out/in at bit 31 or 39
// - narrow rotate or logical shift clears guard bits
// - legacy mode: sign, zero test, signed shifts wide
// - saturation off leaves overflow unsaturated
// - narrow saturation to 007fffffff or ff80000000
// - wide saturation to 7fffffffff or 8000000000
// - extension off zero-extends short operands
// - extension on sign-extends short operands
// - dual mode extends upper half to 24 bits
// - narrow signed shift fills guard bits by mode
// - signed right shift extends only with extension on and no unsigned qualifier
// - conditional subtract correct per extension mode
// - unsigned operations always zero-extend operands
// - mac inputs always sign-extend to 17 bits
// - unsigned qualifier forces unsigned treatment; the code still sign-extends mac inputs and keeps the legacy signed shift width
// - legacy compatibility flag steers sign, zero test and signed shift width
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module dacc_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic busy
);
    ////////////////////////////////////////////////////////////////////////
    // registers
    dacc_pkg::dacc_mode_t mode_reg;
    dacc_pkg::dacc_mode_t exec_mode_reg;
    dacc_pkg::dacc_cmd_t cmd_reg;
    dacc_pkg::dacc_flags_t flags_reg;
    dacc_pkg::dacc_flags_t flags_next;
    dacc_pkg::dacc_state_t state_reg;
    logic [39:0] opa_reg;
    logic [15:0] opb_reg;
    logic [39:0] res_reg;
    logic [39:0] res_next;
    logic [31:0] prdata_next;
    logic [33:0] mac_product;

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    logic acc_phase;
    logic wr_en;
    logic hit_status;
    logic hit_opa_lo;
    logic hit_opa_hi;
    logic hit_opb;
    logic hit_cmd;
    logic hit_res_lo;
    logic hit_res_hi;
    logic hit_flags;
    logic hit_mac;
    logic addr_ok;

    assign acc_phase = psel && penable;
    assign wr_en = acc_phase && pwrite;
    assign hit_status = paddr == dacc_pkg::OFF_STATUS;
    assign hit_opa_lo = paddr == dacc_pkg::OFF_OPA_LO;
    assign hit_opa_hi = paddr == dacc_pkg::OFF_OPA_HI;
    assign hit_opb = paddr == dacc_pkg::OFF_OPB;
    assign hit_cmd = paddr == dacc_pkg::OFF_CMD;
    assign hit_res_lo = paddr == dacc_pkg::OFF_RES_LO;
    assign hit_res_hi = paddr == dacc_pkg::OFF_RES_HI;
    assign hit_flags = paddr == dacc_pkg::OFF_FLAGS;
    assign hit_mac = paddr == dacc_pkg::OFF_MAC;
    assign addr_ok = hit_status | hit_opa_lo | hit_opa_hi | hit_opb | hit_cmd
                   | hit_res_lo | hit_res_hi | hit_flags | hit_mac;

    ////////////////////////////////////////////////////////////////////////
    // mode decode at execute stage
    logic wide;
    logic sign_wide;
    logic sat_en;
    logic sxt;
    logic signed_op;
    logic unsigned_op;
    logic [5:0] msb;

    assign wide = exec_mode_reg.wide_accum_mode;
    assign sat_en = exec_mode_reg.dunit_saturate_enable;
    assign sign_wide = wide | exec_mode_reg.legacy_compat_mode;
    assign unsigned_op = cmd_reg.op inside {dacc_pkg::OP_AND, dacc_pkg::OP_OR,
        dacc_pkg::OP_XOR, dacc_pkg::OP_SFTL, dacc_pkg::OP_ROL, dacc_pkg::OP_ROR};
    assign sxt = exec_mode_reg.sign_extend_mode && !cmd_reg.uns_qual
                 && !unsigned_op;
    assign signed_op = !unsigned_op;
    assign msb = wide ? 6'd39 : 6'd31;

    ////////////////////////////////////////////////////////////////////////
    // operand extension
    logic [39:0] opb_ext;
    logic [23:0] dual_hi;
    logic [23:0] dual_hi_a;
    logic [15:0] dual_lo;
    logic [39:0] sub_b;

    assign opb_ext = sxt ? {{24{opb_reg[15]}}, opb_reg} : {24'h000000, opb_reg};
    assign dual_hi = sxt ? {{8{opb_reg[15]}}, opb_reg} : {8'h00, opb_reg};
    assign dual_hi_a = sxt ? {{8{opa_reg[31]}}, opa_reg[31:16]}
                           : {8'h00, opa_reg[31:16]};
    assign dual_lo = opa_reg[15:0] + opb_reg;
    assign sub_b = {opb_ext[24:0], 15'h0000};

    ////////////////////////////////////////////////////////////////////////
    // adder with carry and overflow at selected position
    logic [40:0] sum;
    logic [39:0] add_b;
    logic is_sub;
    logic carry_sel;
    logic ovf_sel;
    logic a_sign;
    logic b_sign;
    logic r_sign;

    assign is_sub = cmd_reg.op == dacc_pkg::OP_SUB || cmd_reg.op == dacc_pkg::OP_SUBC;
    assign add_b = cmd_reg.op == dacc_pkg::OP_SUBC ? sub_b : opb_ext;
    assign sum = is_sub ? {1'b0, opa_reg} + {1'b0, ~add_b} + 41'h00000000001
                        : {1'b0, opa_reg} + {1'b0, add_b};
    assign a_sign = wide ? opa_reg[39] : opa_reg[31];
    assign b_sign = wide ? (add_b[39] ^ is_sub) : (add_b[31] ^ is_sub);
    assign r_sign = wide ? sum[39] : sum[31];
    assign carry_sel = wide ? sum[40]
                            : (opa_reg[32] ^ add_b[32] ^ sum[32]) ^ is_sub;
    assign ovf_sel = (a_sign == b_sign) && (r_sign != a_sign);

    ////////////////////////////////////////////////////////////////////////
    // saturation
    logic [39:0] sat_pos;
    logic [39:0] sat_neg;
    logic [39:0] add_res;

    assign sat_pos = wide ? dacc_pkg::SAT40_POS : dacc_pkg::SAT32_POS;
    assign sat_neg = wide ? dacc_pkg::SAT40_NEG : dacc_pkg::SAT32_NEG;
    assign add_res = (sat_en && ovf_sel) ? (a_sign ? sat_neg : sat_pos)
                                         : sum[39:0];

    ////////////////////////////////////////////////////////////////////////
    // conditional subtract
    logic [39:0] subc_res;

    assign subc_res = sum[39] ? {opa_reg[38:0], 1'b0}
                              : {sum[38:0], 1'b1};

    ////////////////////////////////////////////////////////////////////////
    // shifts and rotates
    logic [39:0] sh_src;
    logic sh_fill;
    logic [39:0] sft_res;
    logic sh_out;
    logic arith_wide;

    assign arith_wide = sign_wide && signed_op;
    assign sh_src = (wide || arith_wide) ? opa_reg : {8'h00, opa_reg[31:0]};
    assign sh_fill = (cmd_reg.op == dacc_pkg::OP_SFTA) && sxt
                     && (arith_wide ? opa_reg[39] : opa_reg[31]);

    always_comb begin
        logic [79:0] dbl;
        logic [5:0] n;
        logic [5:0] w;
        dbl = 80'h0;
        n = cmd_reg.shift_amt;
        w = (wide || arith_wide) ? 6'd40 : 6'd32;
        sft_res = 40'h0;
        sh_out = 1'b0;
        if (n > w) begin
            n = w;
        end
        unique case (cmd_reg.op)
            dacc_pkg::OP_ROL: begin
                sh_out = opa_reg[msb];
                sft_res = wide ? {opa_reg[38:0], cmd_reg.carry_in}
                               : {8'h00, opa_reg[30:0], cmd_reg.carry_in};
            end
            dacc_pkg::OP_ROR: begin
                sh_out = opa_reg[0];
                sft_res = wide ? {cmd_reg.carry_in, opa_reg[39:1]}
                               : {8'h00, cmd_reg.carry_in, opa_reg[31:1]};
            end
            default: begin
                if (cmd_reg.shift_left) begin
                    dbl = {40'h0, sh_src} << n;
                    sh_out = (n == 6'd0) ? 1'b0 : dbl[w];
                    sft_res = dbl[39:0];
                end else begin
                    dbl = {{40{sh_fill}}, sh_src} >> n;
                    if (!(wide || arith_wide)) begin
                        dbl[39:32] = 8'h00;
                        for (int i = 0; i < 32; i++) begin
                            if (i >= 32 - int'(n)) begin
                                dbl[i] = sh_fill;
                            end
                        end
                    end
                    sh_out = (n == 6'd0) ? 1'b0 : sh_src[n - 6'd1];
                    sft_res = dbl[39:0];
                end
                if (!(wide || arith_wide)) begin
                    if (cmd_reg.op == dacc_pkg::OP_SFTA && sxt) begin
                        sft_res[39:32] = {8{sft_res[31]}};
                    end else begin
                        sft_res[39:32] = 8'h00;
                    end
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // result select and flags
    logic [39:0] alu_res;
    logic zero_sel;

    always_comb begin
        alu_res = 40'h0;
        unique case (cmd_reg.op)
            dacc_pkg::OP_ADD, dacc_pkg::OP_SUB: alu_res = add_res;
            dacc_pkg::OP_AND: alu_res = opa_reg & {24'h000000, opb_reg};
            dacc_pkg::OP_OR: alu_res = opa_reg | {24'h000000, opb_reg};
            dacc_pkg::OP_XOR: alu_res = opa_reg ^ {24'h000000, opb_reg};
            dacc_pkg::OP_SUBC: alu_res = subc_res;
            dacc_pkg::OP_DUAL: alu_res = {dual_hi_a + dual_hi, dual_lo};
            dacc_pkg::OP_LOAD: alu_res = opb_ext;
            dacc_pkg::OP_MAC: alu_res = {{6{mac_product[33]}}, mac_product};
            default: alu_res = sft_res;
        endcase
    end

    assign res_next = alu_res;
    assign zero_sel = sign_wide ? (alu_res == 40'h0)
                                : (alu_res[31:0] == 32'h0);
    assign flags_next.carry = (cmd_reg.op inside {dacc_pkg::OP_ADD, dacc_pkg::OP_SUB})
                              ? carry_sel : 1'b0;
    assign flags_next.overflow = (cmd_reg.op inside {dacc_pkg::OP_ADD, dacc_pkg::OP_SUB})
                                 ? ovf_sel : 1'b0;
    assign flags_next.zero = zero_sel;
    assign flags_next.negative = sign_wide ? alu_res[39] : alu_res[31];
    assign flags_next.out_bit = sh_out;

    dacc_mac_ext u_mac (
        .pclk(pclk),
        .presetn(presetn),
        .opd_a(opa_reg[15:0]),
        .opd_b(opb_reg),
        .product_reg(mac_product)
    );

    ////////////////////////////////////////////////////////////////////////
    // read mux
    assign prdata_next = hit_status ? {21'h0, mode_reg.wide_accum_mode,
                            mode_reg.dunit_saturate_enable, mode_reg.sign_extend_mode,
                            2'b00, mode_reg.legacy_compat_mode, 5'h00}
                       : hit_opa_lo ? opa_reg[31:0]
                       : hit_opa_hi ? {24'h0, opa_reg[39:32]}
                       : hit_opb ? {16'h0, opb_reg}
                       : hit_cmd ? {19'h0, cmd_reg}
                       : hit_res_lo ? res_reg[31:0]
                       : hit_res_hi ? {24'h0, res_reg[39:32]}
                       : hit_flags ? {27'h0, flags_reg}
                       : hit_mac ? {{6{mac_product[33]}}, mac_product[25:0]}
                       : 32'h0;

    ////////////////////////////////////////////////////////////////////////
    // sequencing and storage
    logic launch;

    assign launch = wr_en && hit_cmd && state_reg == dacc_pkg::ST_IDLE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= dacc_pkg::ST_IDLE;
        end else begin
            unique case (state_reg)
                dacc_pkg::ST_IDLE: if (launch) state_reg <= dacc_pkg::ST_EXEC;
                dacc_pkg::ST_EXEC: state_reg <= dacc_pkg::ST_DONE;
                dacc_pkg::ST_DONE: state_reg <= dacc_pkg::ST_IDLE;
                default: state_reg <= dacc_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= {dacc_pkg::RST_WIDE, dacc_pkg::RST_SAT, dacc_pkg::RST_SXT,
                         dacc_pkg::RST_LEGACY};
            exec_mode_reg <= {dacc_pkg::RST_WIDE, dacc_pkg::RST_SAT, dacc_pkg::RST_SXT,
                              dacc_pkg::RST_LEGACY};
            cmd_reg <= '0;
            opa_reg <= 40'h0;
            opb_reg <= 16'h0;
        end else begin
            if (wr_en && hit_status) begin
                mode_reg.wide_accum_mode <= pwdata[dacc_pkg::STAT_WIDE_BIT];
                mode_reg.dunit_saturate_enable <= pwdata[dacc_pkg::STAT_SAT_BIT];
                mode_reg.sign_extend_mode <= pwdata[dacc_pkg::STAT_SXT_BIT];
                mode_reg.legacy_compat_mode <= pwdata[dacc_pkg::STAT_LEGACY_BIT];
            end
            if (wr_en && hit_opa_lo) opa_reg[31:0] <= pwdata;
            if (wr_en && hit_opa_hi) opa_reg[39:32] <= pwdata[7:0];
            if (wr_en && hit_opb) opb_reg <= pwdata[15:0];
            if (launch) begin
                cmd_reg <= pwdata[12:0];
                exec_mode_reg <= mode_reg;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_reg <= 40'h0;
            flags_reg <= '0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            busy <= 1'b0;
        end else begin
            if (state_reg == dacc_pkg::ST_EXEC) begin
                res_reg <= res_next;
                flags_reg <= flags_next;
            end
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata <= prdata_next;
            busy <= launch || (state_reg == dacc_pkg::ST_EXEC);
        end
    end
endmodule

/* File: hdl/dacc_pkg.sv */
// package for the d-unit accumulator mode logic
// assumes nothing beyond a systemverilog compiler
package dacc_pkg;

    localparam int ACC_W = 40;
    localparam int OPD_W = 16;
    localparam int MAC_W = 17;
    localparam int HALF_W = 24;
    localparam int SHIFT_W = 6;

    // status register one layout
    localparam int STAT_SXT_BIT = 8;
    localparam int STAT_SAT_BIT = 9;
    localparam int STAT_WIDE_BIT = 10;
    localparam int STAT_LEGACY_BIT = 5;

    // register offsets on apb
    localparam logic [11:0] OFF_STATUS = 12'h000;
    localparam logic [11:0] OFF_OPA_LO = 12'h004;
    localparam logic [11:0] OFF_OPA_HI = 12'h008;
    localparam logic [11:0] OFF_OPB = 12'h00c;
    localparam logic [11:0] OFF_CMD = 12'h010;
    localparam logic [11:0] OFF_RES_LO = 12'h014;
    localparam logic [11:0] OFF_RES_HI = 12'h018;
    localparam logic [11:0] OFF_FLAGS = 12'h01c;
    localparam logic [11:0] OFF_MAC = 12'h020;

    // reset values of the mode bits
    localparam logic RST_WIDE = 1'b0;
    localparam logic RST_SAT = 1'b0;
    localparam logic RST_SXT = 1'b1;
    localparam logic RST_LEGACY = 1'b1;

    // saturation values
    localparam logic [39:0] SAT32_POS = 40'h007fffffff;
    localparam logic [39:0] SAT32_NEG = 40'hff80000000;
    localparam logic [39:0] SAT40_POS = 40'h7fffffffff;
    localparam logic [39:0] SAT40_NEG = 40'h8000000000;

    typedef enum logic [3:0] {
        OP_ADD = 4'h0,
        OP_SUB = 4'h1,
        OP_AND = 4'h2,
        OP_OR = 4'h3,
        OP_XOR = 4'h4,
        OP_SFTA = 4'h5,
        OP_SFTL = 4'h6,
        OP_ROL = 4'h7,
        OP_ROR = 4'h8,
        OP_SUBC = 4'h9,
        OP_DUAL = 4'ha,
        OP_LOAD = 4'hb,
        OP_MAC = 4'hc
    } dacc_op_t;

    typedef struct packed {
        logic wide_accum_mode;
        logic dunit_saturate_enable;
        logic sign_extend_mode;
        logic legacy_compat_mode;
    } dacc_mode_t;

    typedef struct packed {
        dacc_op_t op;
        logic uns_qual;
        logic shift_left;
        logic carry_in;
        logic [5:0] shift_amt;
    } dacc_cmd_t;

    typedef struct packed {
        logic carry;
        logic overflow;
        logic zero;
        logic negative;
        logic out_bit;
    } dacc_flags_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_DONE = 3'b100
    } dacc_state_t;

endpackage

/* File: hdl/dacc_mac_ext.sv */
// operand extension for the multiply-accumulate path
// assumes a 16-bit operand pair from the main unit
`timescale 1ns/1ps
module dacc_mac_ext (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] opd_a,
    input wire logic [15:0] opd_b,
    output logic [33:0] product_reg
);
    logic [16:0] ext_a;
    logic [16:0] ext_b;
    logic [33:0] product_next;

    assign ext_a = {opd_a[15], opd_a};
    assign ext_b = {opd_b[15], opd_b};
    assign product_next = 34'($signed(ext_a) * $signed(ext_b));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            product_reg <= 34'h000000000;
        end else begin
            product_reg <= product_next;
        end
    end
endmodule

/* File: tb/dacc_cpu_model.sv */
// apb master standing in for the cpu decode and accumulator file
// assumes the dacc_unit apb slave on the same pclk
`timescale 1ns/1ps
module dacc_cpu_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one apb transfer, held until pready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released bus shows inverted values
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

/* File: tb/dacc_unit_props.sv */
// assertions on the apb ports of dacc_unit
// assumes a single pclk domain with async active-low presetn
`timescale 1ns/1ps
module dacc_unit_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic st_wr_reg;
    wire setup = psel && !penable;
    wire done_xfer = psel && penable && pready;
    wire mapped = (paddr[1:0] == 2'b00) && (paddr <= 12'h020);
    wire rd_hit = done_xfer && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_wr_reg <= 1'b0;
        end else if (done_xfer && pwrite && paddr == dacc_pkg::OFF_STATUS) begin
            st_wr_reg <= 1'b1;
        end
    end

    sequence s_cmd;
        done_xfer && pwrite && paddr == dacc_pkg::OFF_CMD && !busy;
    endsequence
    sequence s_run;
        busy [*2] ##1 !busy;
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    AST_CMD_BUSY: assert property (s_cmd |=> s_run)
        else $error("busy window wrong after command");
    AST_READY_SETUP: assert property (setup |=> pready && (pslverr != $past(mapped)))
        else $error("access answer or error flag wrong");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready held too long");
    AST_IDLE_QUIET: assert property (!psel |=> !pready)
        else $error("pready without select");
    AST_ERR_RD_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h00000000)
        else $error("unmapped read returned data");
    AST_RESHI_CLEAN: assert property (rd_hit && paddr == dacc_pkg::OFF_RES_HI
        |-> prdata[31:8] == 24'h000000)
        else $error("result high word beyond 40 bits");
    AST_FLAGS_CLEAN: assert property (rd_hit && paddr == dacc_pkg::OFF_FLAGS
        |-> prdata[31:5] == 27'h0000000)
        else $error("flag word has stray bits");
    AST_STATUS_RESET: assert property (rd_hit && paddr == dacc_pkg::OFF_STATUS && !st_wr_reg
        |-> prdata == 32'h00000120)
        else $error("status reset value wrong");
endmodule

bind dacc_unit dacc_unit_props i_dacc_unit_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy(busy));

/* File: tb/tb_top.sv */
// self-checking bench for dacc_unit over apb
// assumes dacc_cpu_model as master and the bound property checker
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, erv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [39:0] res;
    logic [4:0] flg;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;

    initial pclk = 1'b0;
    always #10 pclk = ~pclk;

    dacc_unit i_dacc_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .busy(busy));
    dacc_cpu_model i_dacc_cpu_model (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    ////////////////////////////////////////////////////////////////////////////////
    task summarize;
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            summarize();
        end
    end

    function automatic logic [31:0] cw(dacc_pkg::dacc_op_t op, int u, int l, int c, int n);
        return {19'h0, op, u[0], l[0], c[0], n[5:0]};
    endfunction

    task wr(input logic [11:0] a, input logic [31:0] d);
        i_dacc_cpu_model.xfer(1'b1, a, d, rdv, erv);
    endtask

    task rd(input logic [11:0] a);
        i_dacc_cpu_model.xfer(1'b0, a, 32'h00000000, rdv, erv);
    endtask

    // modes are cleared right after the command to show execute-stage sampling
    task run(input logic [31:0] st, input logic [39:0] a, input logic [15:0] b,
             input logic [31:0] c, input logic [39:0] e);
        int n;
        logic [31:0] lo;
        n = 0;
        wr(dacc_pkg::OFF_STATUS, st);
        wr(dacc_pkg::OFF_OPA_LO, a[31:0]);
        wr(dacc_pkg::OFF_OPA_HI, {24'h000000, a[39:32]});
        wr(dacc_pkg::OFF_OPB, {16'h0000, b});
        wr(dacc_pkg::OFF_CMD, c);
        wr(dacc_pkg::OFF_STATUS, 32'h00000000);
        while (busy !== 1'b0 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        `CHK(busy, 1'b0)
        rd(dacc_pkg::OFF_RES_LO);
        lo = rdv;
        rd(dacc_pkg::OFF_RES_HI);
        res = {rdv[7:0], lo};
        rd(dacc_pkg::OFF_FLAGS);
        flg = rdv[4:0];
        `CHK(res, e)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(dacc_pkg::OFF_STATUS);
        `CHK(rdv, 32'h00000120)
        rd(12'h024);
        `CHK({erv, rdv}, 33'h100000000)
        `CHK(erv, 1'b1)
        run(32'h200, 40'h007fffffff, 16'h0001, cw(dacc_pkg::OP_ADD, 0, 0, 0, 0),
            40'h007fffffff);
        `CHK(flg[3], 1'b1)
        run(32'h300, 40'hff80000000, 16'h0001, cw(dacc_pkg::OP_SUB, 0, 0, 0, 0),
            40'hff80000000);
        run(32'h000, 40'h007fffffff, 16'h0001, cw(dacc_pkg::OP_ADD, 0, 0, 0, 0),
            40'h0080000000);
        run(32'h600, 40'h7fffffffff, 16'h0001, cw(dacc_pkg::OP_ADD, 0, 0, 0, 0),
            40'h7fffffffff);
        run(32'h700, 40'h8000000000, 16'h0001, cw(dacc_pkg::OP_SUB, 0, 0, 0, 0),
            40'h8000000000);
        run(32'h600, 40'h007fffffff, 16'h0001, cw(dacc_pkg::OP_ADD, 0, 0, 0, 0),
            40'h0080000000);
        `CHK(flg[3], 1'b0)
        run(32'h000, 40'h00ffffffff, 16'h0001, cw(dacc_pkg::OP_ADD, 0, 0, 0, 0),
            40'h0100000000);
        `CHK({flg[4], flg[2]}, 2'b11)
        run(32'h400, 40'h00ffffffff, 16'h0001, cw(dacc_pkg::OP_ADD, 0, 0, 0, 0),
            40'h0100000000);
        `CHK({flg[4], flg[2]}, 2'b00)
        run(32'h020, 40'hff00000000, 16'h0000, cw(dacc_pkg::OP_ADD, 0, 0, 0, 0),
            40'hff00000000);
        `CHK(flg[2], 1'b0)
        run(32'h400, 40'h0, 16'h8000, cw(dacc_pkg::OP_LOAD, 0, 0, 0, 0), 40'h0000008000);
        run(32'h500, 40'h0, 16'h8000, cw(dacc_pkg::OP_LOAD, 0, 0, 0, 0), 40'hffffff8000);
        run(32'h500, 40'h0, 16'h8000, cw(dacc_pkg::OP_LOAD, 1, 0, 0, 0), 40'h0000008000);
        run(32'h500, 40'hffffffffff, 16'h8000, cw(dacc_pkg::OP_AND, 0, 0, 0, 0),
            40'h0000008000);
        run(32'h100, 40'h0080000000, 16'h0, cw(dacc_pkg::OP_SFTA, 0, 0, 0, 4),
            40'hfff8000000);
        run(32'h000, 40'h0080000000, 16'h0, cw(dacc_pkg::OP_SFTA, 0, 0, 0, 4),
            40'h0008000000);
        run(32'h100, 40'h0080000000, 16'h0, cw(dacc_pkg::OP_SFTA, 1, 0, 0, 4),
            40'h0008000000);
        run(32'h120, 40'h8000000000, 16'h0, cw(dacc_pkg::OP_SFTA, 0, 0, 0, 4),
            40'hf800000000);
        run(32'h000, 40'hff12345678, 16'h0, cw(dacc_pkg::OP_SFTL, 0, 1, 0, 4),
            40'h0023456780);
        `CHK(flg[0], 1'b1)
        run(32'h400, 40'hff12345678, 16'h0, cw(dacc_pkg::OP_SFTL, 0, 1, 0, 4),
            40'hf123456780);
        run(32'h000, 40'h0080000001, 16'h0, cw(dacc_pkg::OP_ROL, 0, 1, 0, 1),
            40'h0000000002);
        `CHK(flg[0], 1'b1)
        run(32'h400, 40'h0080000001, 16'h0, cw(dacc_pkg::OP_ROL, 0, 1, 0, 1),
            40'h0100000002);
        `CHK(flg[0], 1'b0)
        run(32'h000, 40'h0000000001, 16'h0, cw(dacc_pkg::OP_ROR, 0, 0, 1, 1),
            40'h0080000000);
        `CHK(flg[0], 1'b1)
        run(32'h000, 40'h000000ffff, 16'h0002, cw(dacc_pkg::OP_MAC, 0, 0, 0, 0),
            40'hfffffffffe);
        run(32'h000, 40'h0040000000, 16'h8000, cw(dacc_pkg::OP_SUBC, 0, 0, 0, 0),
            40'h0000000001);
        run(32'h100, 40'h0080000001, 16'h8000, cw(dacc_pkg::OP_DUAL, 0, 0, 0, 0),
            40'hff00008001);
        summarize();
    end
endmodule
